// file: src/sccr_pkg.sv
// Constants, register map and types of the system configuration and clock register block
// What this block does
// - Remap 00 fetches vectors from boot ROM
// - Remap 01 fetches vectors from static RAM
// - Remap 10/11 means flash; resets to flash
// - Peripheral reset bits active low
// - Bit0 SPI, bit1 I2C, both reset held
// - Feedback divider M equals field plus one
// - Post divider P encoded 1,2,4,8; ratio 2P
// - PLL status read-only lock bit, resets 0
// - Bypass bit feeds PLL from crystal pins
// - Range bit selects 1-20 or 15-25 MHz
// - Slow divider ratio is 2 times (field+1)
// - Four-bit analog code selects slow frequency
package sccr_pkg;

    // Address width of the register port
    localparam int SCCR_AW = 32;

    // Register byte addresses
    localparam logic [31:0] SCCR_ADDR_REMAP = 32'h40048000;
    localparam logic [31:0] SCCR_ADDR_PRST = 32'h40048004;
    localparam logic [31:0] SCCR_ADDR_PLLCTL = 32'h40048008;
    localparam logic [31:0] SCCR_ADDR_PLLSTAT = 32'h4004800C;
    localparam logic [31:0] SCCR_ADDR_OSCCTL = 32'h40048020;
    localparam logic [31:0] SCCR_ADDR_SLOWCTL = 32'h40048024;

    // Field positions and widths
    localparam int SCCR_REMAP_W = 2;
    localparam int SCCR_PRST_SPI_BIT = 0;
    localparam int SCCR_PRST_I2C_BIT = 1;
    localparam int SCCR_FB_LSB = 0;
    localparam int SCCR_FB_W = 5;
    localparam int SCCR_POST_LSB = 5;
    localparam int SCCR_POST_W = 2;
    localparam int SCCR_LOCK_BIT = 0;
    localparam int SCCR_BYPASS_BIT = 0;
    localparam int SCCR_RANGE_BIT = 1;
    localparam int SCCR_SDIV_LSB = 0;
    localparam int SCCR_SDIV_W = 5;
    localparam int SCCR_SFREQ_LSB = 5;
    localparam int SCCR_SFREQ_W = 4;

    // Reset values
    localparam logic [1:0] SCCR_REMAP_RST = 2'h2;
    localparam logic [1:0] SCCR_PRST_RST = 2'h0;
    localparam logic [4:0] SCCR_FB_RST = 5'h00;
    localparam logic [1:0] SCCR_POST_RST = 2'h0;
    localparam logic SCCR_BYPASS_RST = 1'h0;
    localparam logic SCCR_RANGE_RST = 1'h0;
    localparam logic [4:0] SCCR_SDIV_RST = 5'h00;
    localparam logic [3:0] SCCR_SFREQ_RST = 4'h0;

    // Remap field encodings
    localparam logic [1:0] SCCR_MAP_BOOT = 2'h0;
    localparam logic [1:0] SCCR_MAP_RAM = 2'h1;

    // Lock input synchroniser depth
    localparam int SCCR_SYNC_STAGES = 2;

    // Vector source, one-hot
    typedef enum logic [2:0] {
        SCCR_VEC_BOOT = 3'h1,
        SCCR_VEC_RAM = 3'h2,
        SCCR_VEC_FLASH = 3'h4
    } sccr_vec_e;

endpackage : sccr_pkg

// file: src/sccr_regs.sv
// System configuration and clock control register block
`timescale 1ns/10ps
`default_nettype none
module sccr_regs
    import sccr_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [SCCR_AW-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Vector source selection, one-hot
    output logic vec_boot_o,
    output logic vec_ram_o,
    output logic vec_flash_o,
    // Peripheral reset releases, low holds in reset
    output logic spi_reset_release_o,
    output logic i2c_reset_release_o,
    // PLL settings
    output logic [4:0] feedback_divider_value_o,
    output logic [5:0] fb_ratio_o,
    output logic [1:0] post_sel_o,
    output logic [4:0] post_ratio_o,
    input wire logic pll_lock_i,
    // System oscillator settings
    output logic osc_bypass_o,
    output logic oscillator_range_select_o,
    // Slow oscillator settings
    output logic [4:0] slow_osc_divider_o,
    output logic [6:0] slow_div_ratio_o,
    output logic [3:0] slow_osc_analog_freq_code_o
);

    // Post divider ratio 2P from the field
    function automatic logic [4:0] post_ratio(input logic [1:0] sel);
        logic [4:0] r;
        r = 5'h02 << sel;
        return r;
    endfunction

    // Address match
    function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
        return a == b;
    endfunction

    typedef struct packed {
        logic [1:0] remap;
        logic spi_rel;
        logic i2c_rel;
        logic [4:0] fb;
        logic [1:0] post;
        logic bypass;
        logic range;
        logic [4:0] sdiv;
        logic [3:0] sfreq;
        sccr_vec_e vec;
        logic [5:0] fb_ratio;
        logic [4:0] post_ratio;
        logic [6:0] sdiv_ratio;
        logic [31:0] rdata;
    } sccr_regs_s;

    sccr_regs_s state_reg;
    sccr_regs_s state_next;
    logic lock_sync;

    // Lock arrives from the analog PLL domain
    sccr_sync u_lock_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .async_i(pll_lock_i),
        .sync_o(lock_sync)
    );

    // Next-state logic
    always_comb begin
        state_next = state_reg;
        state_next.rdata = 32'h00000000;
        if (wr_i) begin
            if (hit(addr_i, SCCR_ADDR_REMAP)) begin
                state_next.remap = wdata_i[SCCR_REMAP_W-1:0];
            end
            if (hit(addr_i, SCCR_ADDR_PRST)) begin
                state_next.spi_rel = wdata_i[SCCR_PRST_SPI_BIT];
                state_next.i2c_rel = wdata_i[SCCR_PRST_I2C_BIT];
            end
            if (hit(addr_i, SCCR_ADDR_PLLCTL)) begin
                state_next.fb = wdata_i[SCCR_FB_LSB +: SCCR_FB_W];
                state_next.post = wdata_i[SCCR_POST_LSB +: SCCR_POST_W];
            end
            if (hit(addr_i, SCCR_ADDR_OSCCTL)) begin
                state_next.bypass = wdata_i[SCCR_BYPASS_BIT];
                state_next.range = wdata_i[SCCR_RANGE_BIT];
            end
            if (hit(addr_i, SCCR_ADDR_SLOWCTL)) begin
                state_next.sdiv = wdata_i[SCCR_SDIV_LSB +: SCCR_SDIV_W];
                state_next.sfreq = wdata_i[SCCR_SFREQ_LSB +: SCCR_SFREQ_W];
            end
        end
        if (rd_i) begin
            if (hit(addr_i, SCCR_ADDR_REMAP)) begin
                state_next.rdata[SCCR_REMAP_W-1:0] = state_reg.remap;
            end else if (hit(addr_i, SCCR_ADDR_PRST)) begin
                state_next.rdata[SCCR_PRST_SPI_BIT] = state_reg.spi_rel;
                state_next.rdata[SCCR_PRST_I2C_BIT] = state_reg.i2c_rel;
            end else if (hit(addr_i, SCCR_ADDR_PLLCTL)) begin
                state_next.rdata[SCCR_FB_LSB +: SCCR_FB_W] = state_reg.fb;
                state_next.rdata[SCCR_POST_LSB +: SCCR_POST_W] = state_reg.post;
            end else if (hit(addr_i, SCCR_ADDR_PLLSTAT)) begin
                state_next.rdata[SCCR_LOCK_BIT] = lock_sync;
            end else if (hit(addr_i, SCCR_ADDR_OSCCTL)) begin
                state_next.rdata[SCCR_BYPASS_BIT] = state_reg.bypass;
                state_next.rdata[SCCR_RANGE_BIT] = state_reg.range;
            end else if (hit(addr_i, SCCR_ADDR_SLOWCTL)) begin
                state_next.rdata[SCCR_SDIV_LSB +: SCCR_SDIV_W] = state_reg.sdiv;
                state_next.rdata[SCCR_SFREQ_LSB +: SCCR_SFREQ_W] = state_reg.sfreq;
            end
        end
        case (state_next.remap)
            SCCR_MAP_BOOT: state_next.vec = SCCR_VEC_BOOT;
            SCCR_MAP_RAM: state_next.vec = SCCR_VEC_RAM;
            default: state_next.vec = SCCR_VEC_FLASH;
        endcase
        state_next.fb_ratio = {1'b0, state_next.fb} + 6'h01;
        state_next.post_ratio = post_ratio(state_next.post);
        state_next.sdiv_ratio = 7'({state_next.sdiv, 1'b0}) + 7'h02;
    end

    // State register
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_reg.remap <= SCCR_REMAP_RST;
            state_reg.spi_rel <= SCCR_PRST_RST[SCCR_PRST_SPI_BIT];
            state_reg.i2c_rel <= SCCR_PRST_RST[SCCR_PRST_I2C_BIT];
            state_reg.fb <= SCCR_FB_RST;
            state_reg.post <= SCCR_POST_RST;
            state_reg.bypass <= SCCR_BYPASS_RST;
            state_reg.range <= SCCR_RANGE_RST;
            state_reg.sdiv <= SCCR_SDIV_RST;
            state_reg.sfreq <= SCCR_SFREQ_RST;
            state_reg.vec <= SCCR_VEC_FLASH;
            state_reg.fb_ratio <= 6'h01;
            state_reg.post_ratio <= 5'h02;
            state_reg.sdiv_ratio <= 7'h02;
            state_reg.rdata <= 32'h00000000;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flops
    assign rdata_o = state_reg.rdata;
    assign vec_boot_o = state_reg.vec[0];
    assign vec_ram_o = state_reg.vec[1];
    assign vec_flash_o = state_reg.vec[2];
    assign spi_reset_release_o = state_reg.spi_rel;
    assign i2c_reset_release_o = state_reg.i2c_rel;
    assign feedback_divider_value_o = state_reg.fb;
    assign fb_ratio_o = state_reg.fb_ratio;
    assign post_sel_o = state_reg.post;
    assign post_ratio_o = state_reg.post_ratio;
    assign osc_bypass_o = state_reg.bypass;
    assign oscillator_range_select_o = state_reg.range;
    assign slow_osc_divider_o = state_reg.sdiv;
    assign slow_div_ratio_o = state_reg.sdiv_ratio;
    assign slow_osc_analog_freq_code_o = state_reg.sfreq;

    // Assertions

    a_remap_boot: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (state_reg.remap == 2'h0) |-> vec_boot_o)
        else $error("boot remap not selected");

    a_remap_ram: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (state_reg.remap == 2'h1) |-> (vec_ram_o && !vec_boot_o))
        else $error("ram remap not selected");

    a_remap_flash: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        state_reg.remap[1] |-> (vec_flash_o && !vec_ram_o))
        else $error("flash remap not selected");

    a_vec_onehot: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $onehot({vec_boot_o, vec_ram_o, vec_flash_o}))
        else $error("vector source not one-hot");

    a_remap_wr_boot: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (wr_i && addr_i == SCCR_ADDR_REMAP && wdata_i[1:0] == 2'h0) |=> vec_boot_o)
        else $error("boot code write not applied");

    a_remap_wr_ram: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (wr_i && addr_i == SCCR_ADDR_REMAP && wdata_i[1:0] == 2'h1) |=> vec_ram_o)
        else $error("ram code write not applied");

    a_remap_wr_flash: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (wr_i && addr_i == SCCR_ADDR_REMAP && wdata_i[1]) |=> vec_flash_o)
        else $error("flash code write not applied");

    a_remap_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (rd_i && addr_i == SCCR_ADDR_REMAP) |=> (rdata_o[1:0] == $past(state_reg.remap)))
        else $error("remap readback wrong");

    a_reset_hold: assert property (@(posedge sys_clk_i)
        rst_i |=> (!spi_reset_release_o && !i2c_reset_release_o && vec_flash_o))
        else $error("reset values wrong");

    a_prst_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (wr_i && addr_i == SCCR_ADDR_PRST) |=> (spi_reset_release_o == $past(wdata_i[0])
        && i2c_reset_release_o == $past(wdata_i[1])))
        else $error("peripheral reset write lost");

    a_prst_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!(wr_i && addr_i == SCCR_ADDR_PRST)) |=>
        ($stable(spi_reset_release_o) && $stable(i2c_reset_release_o)))
        else $error("peripheral reset changed without write");

    a_prst_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (rd_i && addr_i == SCCR_ADDR_PRST) |=> (rdata_o == {30'h0,
        $past(i2c_reset_release_o), $past(spi_reset_release_o)}))
        else $error("peripheral reset readback wrong");

    a_fb_ratio: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ##1 (fb_ratio_o == {1'b0, feedback_divider_value_o} + 6'h01))
        else $error("feedback ratio wrong");

    a_fb_min: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (feedback_divider_value_o == 5'h00) |-> (fb_ratio_o == 6'h01))
        else $error("feedback ratio one wrong");

    a_fb_max: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (feedback_divider_value_o == 5'h1F) |-> (fb_ratio_o == 6'h20))
        else $error("feedback ratio 32 wrong");

    a_pll_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (wr_i && addr_i == SCCR_ADDR_PLLCTL) |=> (post_sel_o == $past(wdata_i[6:5])
        && feedback_divider_value_o == $past(wdata_i[4:0])))
        else $error("pll control write lost");

    a_post_one: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (post_sel_o == 2'h0) |-> (post_ratio_o == 5'h02))
        else $error("post ratio two wrong");

    a_post_two: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (post_sel_o == 2'h1) |-> (post_ratio_o == 5'h04))
        else $error("post ratio four wrong");

    a_post_four: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (post_sel_o == 2'h2) |-> (post_ratio_o == 5'h08))
        else $error("post ratio eight wrong");

    a_post_ratio: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (post_sel_o == 2'h3) |-> (post_ratio_o == 5'h10))
        else $error("post ratio wrong");

    a_reset_pll: assert property (@(posedge sys_clk_i)
        rst_i |=> (fb_ratio_o == 6'h01 && post_ratio_o == 5'h02 && post_sel_o == 2'h0))
        else $error("pll reset values wrong");

    a_pll_rsvd: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (rd_i && addr_i == SCCR_ADDR_PLLCTL) |=> (rdata_o[31:7] == 25'h0))
        else $error("pll reserved bits not zero");

    a_lock_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (rd_i && addr_i == SCCR_ADDR_PLLSTAT) |=> (rdata_o[31:1] == 31'h0
        && rdata_o[0] == $past(lock_sync)))
        else $error("lock status read wrong");

    a_osc_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (wr_i && addr_i == SCCR_ADDR_OSCCTL) |=> (osc_bypass_o == $past(wdata_i[0])
        && oscillator_range_select_o == $past(wdata_i[1])))
        else $error("oscillator control write lost");

    a_osc_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!(wr_i && addr_i == SCCR_ADDR_OSCCTL)) |=>
        ($stable(osc_bypass_o) && $stable(oscillator_range_select_o)))
        else $error("oscillator control changed without write");

    a_range_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (rd_i && addr_i == SCCR_ADDR_OSCCTL) |=> (rdata_o == {30'h0,
        $past(oscillator_range_select_o), $past(osc_bypass_o)}))
        else $error("oscillator readback wrong");

    a_slow_ratio: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (slow_osc_divider_o == 5'h1F) |-> (slow_div_ratio_o == 7'h40))
        else $error("slow divider ratio wrong");

    a_slow_min: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (slow_osc_divider_o == 5'h00) |-> (slow_div_ratio_o == 7'h02))
        else $error("slow divider ratio two wrong");

    a_slow_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (wr_i && addr_i == SCCR_ADDR_SLOWCTL) |=>
        (slow_osc_divider_o == $past(wdata_i[4:0])))
        else $error("slow divider write lost");

    a_freq_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (wr_i && addr_i == SCCR_ADDR_SLOWCTL) |=>
        (slow_osc_analog_freq_code_o == $past(wdata_i[8:5])))
        else $error("analog code write lost");

    a_slow_rsvd: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (rd_i && addr_i == SCCR_ADDR_SLOWCTL) |=> (rdata_o[31:9] == 23'h0))
        else $error("slow reserved bits not zero");

    a_rsvd_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (rd_i && addr_i == SCCR_ADDR_REMAP) |=> (rdata_o[31:2] == 30'h0))
        else $error("reserved bits not zero");

    a_rdata_idle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !rd_i |=> (rdata_o == 32'h0))
        else $error("read data not zero when idle");

endmodule // sccr_regs
`default_nettype wire

// file: src/sccr_sync.sv
// Two-flop synchroniser for a level arriving from another domain
`timescale 1ns/10ps
`default_nettype none
module sccr_sync
    import sccr_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Level in and out
    input wire logic async_i,
    output logic sync_o
);

    typedef struct packed {
        logic meta;
        logic stable;
    } sccr_sync_s;

    sccr_sync_s state_reg;
    sccr_sync_s state_next;

    // First stage feeds only the second
    always_comb begin
        state_next.meta = async_i;
        state_next.stable = state_reg.meta;
    end

    // State register
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_o = state_reg.stable;

endmodule // sccr_sync
`default_nettype wire

// file: test/test_system_config_clock_regs.sv
// Self-checking testbench of the system configuration and clock register block
`timescale 1ns/10ps
`default_nettype none
module test_system_config_clock_regs;
    import sccr_pkg::*;

    // Bench signals
    logic clk, rst, wr, rd, lock;
    logic [31:0] addr, wdata, rdata, d;
    logic vboot, vram, vflash, spi_rel, i2c_rel, byp, rng;
    logic [4:0] fb, pr, sdiv;
    logic [5:0] fbr;
    logic [1:0] ps;
    logic [6:0] sdr;
    logic [3:0] sfq;
    int failures = 0;
    int n_checks = 0;
    logic [31:0] amap [6] = '{SCCR_ADDR_REMAP, SCCR_ADDR_PRST, SCCR_ADDR_PLLCTL,
        SCCR_ADDR_PLLSTAT, SCCR_ADDR_OSCCTL, SCCR_ADDR_SLOWCTL};
    logic [31:0] rmap [6] = '{32'h00000002, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

    // Device under test
    sccr_regs uut (.sys_clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .vec_boot_o(vboot), .vec_ram_o(vram),
        .vec_flash_o(vflash), .spi_reset_release_o(spi_rel), .i2c_reset_release_o(i2c_rel),
        .feedback_divider_value_o(fb), .fb_ratio_o(fbr), .post_sel_o(ps),
        .post_ratio_o(pr), .pll_lock_i(lock), .osc_bypass_o(byp),
        .oscillator_range_select_o(rng), .slow_osc_divider_o(sdiv),
        .slow_div_ratio_o(sdr), .slow_osc_analog_freq_code_o(sfq));

    // Clock, 40 ns period
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Compare one value and count it
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask

    // One-cycle write strobe
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    // One-cycle read strobe, data taken in the following cycle
    task automatic rd_reg(input logic [31:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    // Outputs and readback at reset values
    task automatic chk_reset();
        chk("vec", 32'h1, {vboot, vram, vflash});
        chk("prst", 32'h0, {i2c_rel, spi_rel});
        chk("fbr", 32'h1, fbr);
        chk("pr", 32'h2, pr);
        chk("osc", 32'h0, {rng, byp});
        chk("sdr", 32'h2, sdr);
        for (int i = 0; i < 6; i++) begin
            rd_reg(amap[i], d);
            chk("rst_rd", rmap[i], d);
        end
    endtask

    // Closing report
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        give_verdict();
    end

    // Test sequence
    initial begin
        {rst, wr, rd, lock, addr, wdata} <= {1'b1, 3'h0, 64'h0};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1 chk_reset();
        $display("reset values done");
        // Remap codes, reserved ones written, back-to-back read
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            {addr, wdata, wr} <= {SCCR_ADDR_REMAP, 32'hFFFFFFFC | m, 1'b1};
            @(posedge clk);
            wr <= 1'b0;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1 chk("remap_rd", m, rdata);
            chk("vec", (m == 0) ? 4 : (m == 1) ? 2 : 1, {vboot, vram, vflash});
        end
        $display("remap done");
        // Peripheral reset release bits
        for (int p = 0; p < 4; p++) begin
            wr_reg(SCCR_ADDR_PRST, 32'hFFFFFFFC | p);
            chk("prst", p, {i2c_rel, spi_rel});
            rd_reg(SCCR_ADDR_PRST, d);
            chk("prst_rd", p, d);
        end
        $display("peripheral reset done");
        // PLL dividers, upper bits kept clear by software
        for (int i = 0; i < 4; i++) begin
            wr_reg(SCCR_ADDR_PLLCTL, (i << 5) | (i * 10 + (i == 3)));
            chk("fb", i * 10 + (i == 3), fb);
            chk("fbr", i * 10 + (i == 3) + 1, fbr);
            chk("ps", i, ps);
            chk("pr", 2 << i, pr);
            rd_reg(SCCR_ADDR_PLLCTL, d);
            chk("pll_rd", (i << 5) | (i * 10 + (i == 3)), d);
        end
        $display("pll control done");
        // Lock status through the synchroniser, writes ignored
        @(posedge clk);
        lock <= 1'b1;
        wr_reg(SCCR_ADDR_PLLSTAT, 32'h0);
        repeat (3) @(posedge clk);
        rd_reg(SCCR_ADDR_PLLSTAT, d);
        chk("lock1", 32'h1, d);
        @(posedge clk);
        lock <= 1'b0;
        wr_reg(SCCR_ADDR_PLLSTAT, 32'hFFFFFFFF);
        repeat (3) @(posedge clk);
        rd_reg(SCCR_ADDR_PLLSTAT, d);
        chk("lock0", 32'h0, d);
        $display("pll status done");
        // System oscillator bypass and range
        for (int o = 0; o < 4; o++) begin
            wr_reg(SCCR_ADDR_OSCCTL, 32'hFFFFFFFC | o);
            chk("osc", o, {rng, byp});
            rd_reg(SCCR_ADDR_OSCCTL, d);
            chk("osc_rd", o, d);
        end
        $display("oscillator done");
        // Slow oscillator, every analog code, divider ends
        for (int f = 0; f < 16; f++) begin
            wr_reg(SCCR_ADDR_SLOWCTL, 32'hFFFFFE00 | (f << 5) | ((f == 15) ? 31 : f * 2));
            chk("sdiv", (f == 15) ? 31 : f * 2, sdiv);
            chk("sdr", (f == 15) ? 64 : 4 * f + 2, sdr);
            chk("sfq", f, sfq);
            rd_reg(SCCR_ADDR_SLOWCTL, d);
            chk("slow_rd", (f << 5) | ((f == 15) ? 31 : f * 2), d);
        end
        $display("slow oscillator done");
        // Unmapped places read zero and change nothing
        wr_reg(32'h40048010, 32'hFFFFFFFF);
        wr_reg(32'h40048028, 32'hFFFFFFFF);
        rd_reg(32'h40048028, d);
        chk("unmapped", 32'h0, d);
        rd_reg(SCCR_ADDR_PRST, d);
        chk("prst_kept", 32'h3, d);
        $display("unmapped done");
        // Second reset in mid-run
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 chk_reset();
        $display("second reset done");
        give_verdict();
    end
endmodule // test_system_config_clock_regs
`default_nettype wire
